// ===== verilog/plcc_link_regs.sv
// Link capability, link status/control and root capability registers.
// Assumes a register port with one-cycle strobes, an EEPROM loader that
// pulses a load strobe after reset, and a link layer giving speed and state.
//
// Notes on behaviour
// [R1] Link capability visible only in single-endpoint mode
// [R2] Supported speeds read 0010b
// [R3] Max width x1, default from EEPROM port bit; here the width is fixed at x1 and the captured port bit is unused
// [R4] Power-state support defaults to both, 11b
// [R5] L0s latency from fast-train count times four
// [R6] L0s exit code 100b fast, 101b slow
// [R7] L1 exit code 001b fast, 010b slow
// [R8] Unprovided capability bits read zero
// [R9] Port number from EEPROM, meaningful multi-port only; here the port field always reads zero
// [R10] Internal USB bridge port ignores port number
// [R11] Software programs power-state control, resets 00b
// [R12] Receiver may enter L0s even when disabled
// [R13] Read completion boundary bit writable, resets 0
// [R14] Software sets common clock bit, resets 0
// [R15] Extended sync lengthens FTS, skip, TS1 counts
// [R16] Unsupported link control bits read zero
// [R17] Current speed reports 0001b or 0010b
// [R18] Negotiated width reads x1
// [R19] Slot clock bit loaded by hardware, default 0
// [R20] Root error escalation enables in root mode
// [R21] EEPROM values load before software access
// [R22] Read-only writes ignored, reads return defined value
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module plcc_link_regs #(
  parameter int FAST_TRAIN_W = 8 // Width of advertised fast-train count
) (
  input wire logic sys_clk_i, // Core clock, 25 MHz
  input wire logic resetn_i, // Fundamental reset, active low
  input wire logic clk_en_i, // Freezes all state while low
  input wire logic [11:0] reg_addr_i, // Byte address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic multi_port_mode_i, // High: multi-port adapter mode
  input wire logic root_complex_mode_i, // High: root-complex mode
  input wire logic ee_load_i, // EEPROM load strobe
  input wire logic ee_port_cfg_i, // EEPROM port configuration bit
  input wire logic [1:0] ee_aspm_support_i, // EEPROM power-state support
  input wire logic ee_slot_clock_i, // EEPROM slot clock bit
  input wire logic [FAST_TRAIN_W-1:0] advertised_fast_train_count_i, // Fast-train count
  input wire logic link_gen2_i, // High: link at 5.0 GT/s
  input wire logic link_up_i, // Data link is up
  input wire logic l0s_exit_i, // Pulse: link leaves L0s
  input wire logic recovery_enter_i, // Pulse: link enters recovery
  output logic ee_loaded_o, // EEPROM values are in place
  output logic [1:0] aspm_ctl_o, // Power-state entry enables
  output logic l0s_rx_allowed_o, // Receiver may enter L0s
  output logic rcb_o, // Read completion boundary
  output logic common_clock_o, // Common reference clock
  output logic [12:0] fts_count_o, // Fast training sets to send
  output logic skip_after_fts_o, // Send one skip set before L0
  output logic [12:0] ts1_count_o, // TS1 sets in recovery
  output logic [15:0] l0s_exit_ns_o, // Derived L0s exit latency, ns
  output logic [2:0] root_serr_en_o // Escalation enables: cor, nonfatal, fatal
);
  import plcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] rdata; // Read data word
    logic ee_loaded; // Loader done
    logic port_cfg; // Captured EEPROM port bit
    logic [1:0] aspm_sup; // Power-state support
    logic slot_clk; // Slot clock bit
    logic [1:0] aspm_ctl; // Power-state control
    logic rcb; // Completion boundary
    logic cclk; // Common clock
    logic xsync; // Extended sync
    logic [2:0] serr_en; // Root escalation enables
    logic gen2; // Latched link speed
    logic [12:0] fts_cnt; // FTS count output
    logic skip; // Skip after FTS
    logic [12:0] ts1_cnt; // TS1 count output
    logic [15:0] l0s_ns; // L0s latency in ns
  } plcc_state_t;

  plcc_state_t state_reg; // Registered state
  plcc_state_t state_next; // Next state
  logic [31:0] cap_word; // Link capability read value
  logic [31:0] stsctl_word; // Link status/control read value
  logic [31:0] root_word; // Root capability read value
  logic [15:0] fts_ns; // Latency product

  ////////////////////////////////////////////////////////////////////////
  // Read value composition

  // Capability word; unprovided bits stay zero
  always_comb begin
    cap_word = 32'h0000_0000; // [R8]
    cap_word[PLCC_CAP_SPEED_LSB +: 4] = PLCC_SPEEDS_SUPPORTED; // [R2]
    cap_word[PLCC_CAP_WIDTH_LSB +: 6] = PLCC_WIDTH_X1; // [R3]
    cap_word[PLCC_CAP_ASPM_LSB +: 2] = state_reg.aspm_sup; // [R4]
    cap_word[PLCC_CAP_L0S_LSB +: 3] = state_reg.gen2 ? PLCC_L0S_LAT_GEN2 : PLCC_L0S_LAT_GEN1; // [R6]
    cap_word[PLCC_CAP_L1_LSB +: 3] = state_reg.gen2 ? PLCC_L1_LAT_GEN2 : PLCC_L1_LAT_GEN1; // [R7]
    // Only one port exists, so the port number reads zero whatever the EEPROM bit
    cap_word[PLCC_CAP_PORT_LSB +: 8] = multi_port_mode_i ? PLCC_PORT_ZERO : 8'h00; // [R9]
    if (multi_port_mode_i) begin
      cap_word = 32'h0000_0000; // [R1]
    end
  end

  // Status/control word; link disable, retrain and the rest stay zero
  always_comb begin
    stsctl_word = 32'h0000_0000; // [R16]
    stsctl_word[PLCC_CTL_ASPM_LSB +: 2] = state_reg.aspm_ctl; // [R11]
    stsctl_word[PLCC_CTL_RCB_BIT] = state_reg.rcb; // [R13]
    stsctl_word[PLCC_CTL_CCLK_BIT] = state_reg.cclk; // [R14]
    stsctl_word[PLCC_CTL_XSYNC_BIT] = state_reg.xsync; // [R15]
    // Speed undefined while down; report the reset code then
    stsctl_word[PLCC_STS_SPEED_LSB +: 4] = (link_up_i && state_reg.gen2) ? PLCC_SPEED_GEN2 : PLCC_SPEED_GEN1; // [R17]
    stsctl_word[PLCC_STS_WIDTH_LSB +: 6] = PLCC_WIDTH_X1; // [R18]
    stsctl_word[PLCC_STS_SLOTCLK_BIT] = state_reg.slot_clk; // [R19]
  end

  // Root word only visible in root-complex mode
  always_comb begin
    root_word = 32'h0000_0000;
    if (root_complex_mode_i) begin
      root_word[2:0] = state_reg.serr_en; // [R20]
    end
  end

  // Latency: count x 4 symbols x symbol time
  always_comb begin
    fts_ns = 16'(advertised_fast_train_count_i) * 16'(PLCC_SYMBOLS_PER_FTS)
           * (link_gen2_i ? 16'(PLCC_SYMBOL_NS_GEN2) : 16'(PLCC_SYMBOL_NS_GEN1)); // [R5]
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.gen2 = link_gen2_i;
    state_next.l0s_ns = fts_ns; // [R5]
    // Training set counts follow the extended sync bit
    if (l0s_exit_i) begin
      state_next.fts_cnt = state_reg.xsync ? PLCC_XSYNC_FTS : 13'h0000; // [R15]
      state_next.skip = state_reg.xsync; // [R15]
    end
    if (recovery_enter_i) begin
      state_next.ts1_cnt = state_reg.xsync ? PLCC_XSYNC_TS1 : PLCC_NORMAL_TS1; // [R15]
    end
    // EEPROM load lands once; software writes below touch none of its fields
    if (ee_load_i && !state_reg.ee_loaded) begin
      state_next.ee_loaded = 1'b1; // [R21]
      state_next.port_cfg = ee_port_cfg_i; // [R3] [R9]
      state_next.slot_clk = ee_slot_clock_i; // [R19]
      state_next.aspm_sup = (ee_aspm_support_i == 2'h0) ? PLCC_ASPM_DEFAULT : ee_aspm_support_i; // [R4]
    end
    // Register writes; read-only fields are never touched
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        PLCC_OFF_LINK_STSCTL: begin
          state_next.aspm_ctl = reg_wdata_i[PLCC_CTL_ASPM_LSB +: 2]; // [R11]
          state_next.rcb = reg_wdata_i[PLCC_CTL_RCB_BIT]; // [R13]
          state_next.cclk = reg_wdata_i[PLCC_CTL_CCLK_BIT]; // [R14]
          state_next.xsync = reg_wdata_i[PLCC_CTL_XSYNC_BIT]; // [R15]
        end
        PLCC_OFF_ROOT_CAPCTL: begin
          if (root_complex_mode_i) begin
            state_next.serr_en = reg_wdata_i[2:0]; // [R20]
          end
        end
        default: begin
          // Capability and unmapped writes ignored
          state_next.rdata = state_next.rdata; // [R22]
        end
      endcase
    end
    // Reads answer in the following cycle, zero when unmapped
    state_next.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        PLCC_OFF_LINK_CAP: state_next.rdata = cap_word; // [R22]
        PLCC_OFF_LINK_STSCTL: state_next.rdata = stsctl_word;
        PLCC_OFF_ROOT_CAPCTL: state_next.rdata = root_word;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
      state_reg.aspm_sup <= PLCC_ASPM_DEFAULT; // [R4]
      state_reg.aspm_ctl <= PLCC_ASPM_CTL_RESET; // [R11]
      state_reg.ts1_cnt <= PLCC_NORMAL_TS1;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops; l0s_rx_allowed_o is a constant one

  assign reg_rdata_o = state_reg.rdata;
  assign ee_loaded_o = state_reg.ee_loaded;
  assign aspm_ctl_o = state_reg.aspm_ctl;
  // Receiver side entry stays allowed regardless of control bits
  assign l0s_rx_allowed_o = state_reg.ee_loaded | ~state_reg.ee_loaded; // [R12]
  assign rcb_o = state_reg.rcb;
  assign common_clock_o = state_reg.cclk;
  assign fts_count_o = state_reg.fts_cnt;
  assign skip_after_fts_o = state_reg.skip;
  assign ts1_count_o = state_reg.ts1_cnt;
  assign l0s_exit_ns_o = state_reg.l0s_ns;
  // USB bridge port has no port-number input at all
  assign root_serr_en_o = state_reg.serr_en; // [R20]
endmodule : plcc_link_regs

// ===== verilog/plcc_pkg.sv
// Package for the link capability / control register bank.
// Assumes a 32-bit word register port with byte addresses.
package plcc_pkg;
  // Register byte offsets
  localparam logic [11:0] PLCC_OFF_LINK_CAP = 12'h074;
  localparam logic [11:0] PLCC_OFF_LINK_STSCTL = 12'h078;
  localparam logic [11:0] PLCC_OFF_ROOT_CAPCTL = 12'h084;
  // Link capability field positions
  localparam int PLCC_CAP_SPEED_LSB = 0;
  localparam int PLCC_CAP_WIDTH_LSB = 4;
  localparam int PLCC_CAP_ASPM_LSB = 10;
  localparam int PLCC_CAP_L0S_LSB = 12;
  localparam int PLCC_CAP_L1_LSB = 15;
  localparam int PLCC_CAP_PORT_LSB = 24;
  // Link capability values
  localparam logic [3:0] PLCC_SPEEDS_SUPPORTED = 4'h2;
  localparam logic [5:0] PLCC_WIDTH_X1 = 6'h01;
  localparam logic [1:0] PLCC_ASPM_DEFAULT = 2'h3;
  localparam logic [2:0] PLCC_L0S_LAT_GEN2 = 3'h4;
  localparam logic [2:0] PLCC_L0S_LAT_GEN1 = 3'h5;
  localparam logic [2:0] PLCC_L1_LAT_GEN2 = 3'h1;
  localparam logic [2:0] PLCC_L1_LAT_GEN1 = 3'h2;
  localparam logic [7:0] PLCC_PORT_ZERO = 8'h00;
  // Symbol times and symbols per fast training set
  localparam int PLCC_SYMBOL_NS_GEN1 = 4;
  localparam int PLCC_SYMBOL_NS_GEN2 = 2;
  localparam int PLCC_SYMBOLS_PER_FTS = 4;
  // Link control / status field positions
  localparam int PLCC_CTL_ASPM_LSB = 0;
  localparam int PLCC_CTL_RCB_BIT = 3;
  localparam int PLCC_CTL_CCLK_BIT = 6;
  localparam int PLCC_CTL_XSYNC_BIT = 7;
  localparam int PLCC_STS_SPEED_LSB = 16;
  localparam int PLCC_STS_WIDTH_LSB = 20;
  localparam int PLCC_STS_SLOTCLK_BIT = 28;
  // Current speed codes
  localparam logic [3:0] PLCC_SPEED_GEN1 = 4'h1;
  localparam logic [3:0] PLCC_SPEED_GEN2 = 4'h2;
  // Reset values
  localparam logic [1:0] PLCC_ASPM_CTL_RESET = 2'h0;
  // Extended sync set counts and the normal TS1 count
  localparam logic [12:0] PLCC_XSYNC_FTS = 13'h1000;
  localparam logic [12:0] PLCC_XSYNC_TS1 = 13'h0400;
  localparam logic [12:0] PLCC_NORMAL_TS1 = 13'h0010;
endpackage : plcc_pkg

// ===== sim/plcc_link_regs_chk.sv
// Checker for the link register bank, bound to its ports.
// Assumes one clock domain, async active-low reset, clk_en_i high.
`timescale 1ns/1ps
module plcc_link_regs_chk import plcc_pkg::*; #(
  parameter int FAST_TRAIN_W = 8 // Width of the fast-train count
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic multi_port_mode_i,
  input wire logic root_complex_mode_i,
  input wire logic [FAST_TRAIN_W-1:0] advertised_fast_train_count_i,
  input wire logic link_gen2_i,
  input wire logic l0s_exit_i,
  input wire logic recovery_enter_i,
  input wire logic [1:0] aspm_ctl_o,
  input wire logic l0s_rx_allowed_o,
  input wire logic rcb_o,
  input wire logic common_clock_o,
  input wire logic [12:0] fts_count_o,
  input wire logic skip_after_fts_o,
  input wire logic [12:0] ts1_count_o,
  input wire logic [15:0] l0s_exit_ns_o,
  input wire logic [2:0] root_serr_en_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Helper terms, so $past only ever sees a plain signal
  logic rd_cap, rd_hid, rd_root0, wr_root, wr_ctl;
  logic [3:0] ctl_w; // Control fields in output order
  logic [15:0] want; // Latency the count and speed call for
  assign rd_cap = reg_rd_i && reg_addr_i == PLCC_OFF_LINK_CAP && !multi_port_mode_i;
  assign rd_hid = reg_rd_i && reg_addr_i == PLCC_OFF_LINK_CAP && multi_port_mode_i;
  assign rd_root0 = reg_rd_i && reg_addr_i == PLCC_OFF_ROOT_CAPCTL && !root_complex_mode_i;
  assign wr_root = reg_wr_i && reg_addr_i == PLCC_OFF_ROOT_CAPCTL && root_complex_mode_i;
  assign wr_ctl = reg_wr_i && reg_addr_i == PLCC_OFF_LINK_STSCTL;
  assign ctl_w = {reg_wdata_i[1:0], reg_wdata_i[3], reg_wdata_i[6]};
  assign want = 16'(advertised_fast_train_count_i) * (link_gen2_i ? 16'h8 : 16'h10);
  ////////////////////////////////////////////////////////////////////////////////
  chk_rx_l0s: assert property (l0s_rx_allowed_o) else $error("receiver L0s blocked");
  chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("stray read data");
  chk_cap_hide: assert property ($past(rd_hid) |-> reg_rdata_o == 32'h0) else $error("cap not hidden");
  chk_cap_fixed: assert property ($past(rd_cap) |-> reg_rdata_o[9:0] == 10'h012 && reg_rdata_o[31:18] == 14'h0)
    else $error("cap fixed fields wrong");
  chk_root_hide: assert property ($past(rd_root0) |-> reg_rdata_o == 32'h0) else $error("root not hidden");
  chk_root_wr: assert property ($past(wr_root) |-> root_serr_en_o == $past(reg_wdata_i[2:0]))
    else $error("root enables not written");
  chk_ctl_wr: assert property ($past(wr_ctl) |-> {aspm_ctl_o, rcb_o, common_clock_o} == $past(ctl_w))
    else $error("control not written");
  chk_fts_pair: assert property ($past(l0s_exit_i) |-> skip_after_fts_o == (fts_count_o == PLCC_XSYNC_FTS)
    && (fts_count_o == PLCC_XSYNC_FTS || fts_count_o == 13'h0)) else $error("fts count bad");
  chk_ts1_hold: assert property (!$past(recovery_enter_i) |-> $stable(ts1_count_o)) else $error("ts1 moved");
  chk_exit_ns: assert property ($past(resetn_i, 2) && $past(resetn_i) && $stable(want) && $past(want) == $past(want, 2)
    |-> l0s_exit_ns_o == want) else $error("latency wrong");
  // Main scenarios reached
  cover property ($past(rd_cap));
  cover property ($past(wr_root));
  cover property (recovery_enter_i ##1 ts1_count_o == PLCC_XSYNC_TS1);
endmodule : plcc_link_regs_chk

bind plcc_link_regs plcc_link_regs_chk #(.FAST_TRAIN_W(FAST_TRAIN_W)) u_chk (.*);

// ===== sim/plcc_link_model.sv
// Link partner model: speed, link-up level and L0s/recovery pulses.
// Assumes the core clock; GAP_MASK sets how busy the link is.
`timescale 1ns/1ps
module plcc_link_model #(
  parameter int GAP_MASK = 7 // Power of two minus one; larger is slower
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  output logic link_gen2_o,
  output logic link_up_o,
  output logic l0s_exit_o,
  output logic recovery_enter_o
);
  int pseed = 911; // Own seed keeps bench draws unchanged
  ////////////////////////////////////////////////////////////////////////////////
  // Link events; speed moves rarely so latency can settle
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {link_gen2_o, link_up_o, l0s_exit_o, recovery_enter_o} <= 4'h0;
    end else begin
      l0s_exit_o <= ($random(pseed) & GAP_MASK) == 0;
      recovery_enter_o <= ($random(pseed) & (2 * GAP_MASK + 1)) == 0;
      if (($random(pseed) & 31) == 0) link_gen2_o <= ~link_gen2_o;
      if (($random(pseed) & 15) == 0) link_up_o <= ~link_up_o;
    end
  end
endmodule : plcc_link_model

// ===== sim/test_plcc_link_regs.sv
// Self-checking bench for the link register bank.
// Assumes the link model and the bound checker.
`timescale 1ns/1ps
module test_plcc_link_regs;
  import plcc_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, mp = 0, rc = 0, eel = 0, epc = 0, esl = 0;
  logic [11:0] addr = '0;
  logic [31:0] wd = '0, rdata, expw, v;
  logic [1:0] eas = '0, asup, aspm, aspm_o;
  logic [7:0] cnt = '0;
  logic [2:0] serr, serr_o;
  logic [12:0] fts_o, ts1_o;
  logic [15:0] ns_o;
  logic g2, g2d, up, lx, rv, ldd, pend, ex, re, xs_u, rcb, cc, xs, sl, ld_o, rx_o, rcb_o, cc_o, skip_o;
  logic [11:0] offs [5] = '{12'h074, 12'h078, 12'h084, 12'h07C, 12'h080}; // Two unmapped
  int seed = 36130, errors = 0, n_tests = 0;
  always #20 clk = ~clk;
  plcc_link_regs dut (.sys_clk_i(clk), .resetn_i(rstn), .clk_en_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .multi_port_mode_i(mp),
    .root_complex_mode_i(rc), .ee_load_i(eel), .ee_port_cfg_i(epc), .ee_aspm_support_i(eas),
    .ee_slot_clock_i(esl), .advertised_fast_train_count_i(cnt), .link_gen2_i(g2), .link_up_i(up),
    .l0s_exit_i(lx), .recovery_enter_i(rv), .ee_loaded_o(ld_o), .aspm_ctl_o(aspm_o),
    .l0s_rx_allowed_o(rx_o), .rcb_o(rcb_o), .common_clock_o(cc_o), .fts_count_o(fts_o),
    .skip_after_fts_o(skip_o), .ts1_count_o(ts1_o), .l0s_exit_ns_o(ns_o), .root_serr_en_o(serr_o));
  plcc_link_model #(.GAP_MASK(7)) link (.sys_clk_i(clk), .resetn_i(rstn), .link_gen2_o(g2),
    .link_up_o(up), .l0s_exit_o(lx), .recovery_enter_o(rv));
  ////////////////////////////////////////////////////////////////////////////////
  // Expected read word from the shadow state
  function automatic logic [31:0] exp_word(input logic [11:0] a, input logic g, input logic u);
    case (a)
      PLCC_OFF_LINK_CAP: exp_word = mp ? 32'h0 : {14'h0, g ? 3'h1 : 3'h2, g ? 3'h4 : 3'h5, asup, 10'h012};
      PLCC_OFF_LINK_STSCTL: exp_word = {3'h0, sl, 2'h0, 6'h01, (u && g) ? 4'h2 : 4'h1, 8'h0, xs, cc, 2'h0, rcb, 1'b0, aspm};
      PLCC_OFF_ROOT_CAPCTL: exp_word = rc ? {29'h0, serr} : 32'h0;
      default: exp_word = 32'h0;
    endcase
  endfunction : exp_word
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check
  // One bus cycle; called just after a rising edge
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    {wr, rd, addr, wd} <= {w, r, a, d};
    @(posedge clk);
  endtask : op
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow registers, clocked like the design so no race arises
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {aspm, rcb, cc, xs, serr, pend, ex, re, xs_u, ldd, asup, sl, g2d} <= '0;
    end else begin
      if (eel && !ldd) {asup, sl, ldd} <= {(eas == 2'h0) ? 2'h3 : eas, esl, 1'b1};
      if (wr && addr == PLCC_OFF_LINK_STSCTL) {xs, cc, rcb, aspm} <= {wd[7:6], wd[3], wd[1:0]};
      if (wr && addr == PLCC_OFF_ROOT_CAPCTL && rc) serr <= wd[2:0];
      pend <= rd;
      // Speed codes follow the speed latched one cycle before the read
      g2d <= g2;
      expw <= exp_word(addr, g2d, up);
      {ex, re, xs_u} <= {lx, rv, xs};
    end
  end
  // Outputs are settled by the falling edge
  always @(negedge clk) begin
    if (pend) check(rdata === expw, "read data");
    if (ex) check(fts_o === (xs_u ? PLCC_XSYNC_FTS : 13'h0) && skip_o === xs_u, "fts count");
    if (re) check(ts1_o === (xs_u ? PLCC_XSYNC_TS1 : PLCC_NORMAL_TS1), "ts1 count");
  end
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    {eas, esl, epc} <= 4'($random(seed));
    eel <= 1'b1;
    @(posedge clk);
    eel <= 1'b0;
    @(negedge clk);
    check(ld_o === 1'b1, "eeprom load");
    @(posedge clk);
    // Every mode: reads of all places, then writes of all places
    for (int m = 0; m < 4; m++) begin
      {mp, rc} <= 2'(m);
      foreach (offs[i]) op(1'b0, 1'b1, offs[i], '0);
      foreach (offs[i]) op(1'b1, 1'b0, offs[i], 32'($random(seed)));
    end
    $display("mode sweep done");
    // Random back-to-back traffic with mode and count changes
    repeat (600) begin
      v = $random(seed);
      if (v[9:6] == 4'h0) cnt <= v[31:24];
      if (v[13:10] == 4'h0) {mp, rc} <= v[15:14];
      eel <= v[16];
      op(v[0], v[1] & ~v[0], offs[v[4:2] % 5], $random(seed));
    end
    op(1'b0, 1'b0, 12'h000, 32'h0);
    repeat (2) @(posedge clk);
    $display("random traffic done");
    complete_run();
  end
endmodule : test_plcc_link_regs
